/* File: design/pan_pkg.sv */
// Package for the PHY auto-negotiation and identifier register bank
package pan_pkg;

   // Register word indices; byte address is four times the index
   localparam logic [5:0] PAN_IDX_CTRL = 6'h00;
   localparam logic [5:0] PAN_IDX_STAT = 6'h01;
   localparam logic [5:0] PAN_IDX_ID   = 6'h03;
   localparam logic [5:0] PAN_IDX_ADV  = 6'h04;
   localparam logic [5:0] PAN_IDX_LP   = 6'h05;

   localparam int         PAN_ADDR_W   = 8;
   localparam int         PAN_DATA_W   = 32;
   localparam int         PAN_REG_W    = 16;

   // Field positions
   localparam int         PAN_CTRL_RESTART_BIT = 9;
   localparam int         PAN_STAT_DONE_BIT    = 5;
   localparam int         PAN_ID_OUI_LSB       = 10;
   localparam int         PAN_ID_MODEL_LSB     = 4;
   localparam int         PAN_ID_REV_LSB       = 0;

   // Writable bits of the advertisement word and visible bits of the partner word
   localparam logic [15:0] PAN_ADV_WR_MASK = 16'h3DFF;
   localparam logic [15:0] PAN_LP_RD_MASK  = 16'h2FFF;

   // Reset values
   localparam logic [4:0] PAN_SEL_8023     = 5'h01;
   localparam logic [1:0] PAN_PAUSE_RST    = 2'h0;
   localparam logic       PAN_TX_RST       = 1'b1;

   // Pause codes, same in advertisement and partner words
   localparam logic [1:0] PAN_PAUSE_NONE = 2'h0;
   localparam logic [1:0] PAN_PAUSE_SYM  = 2'h1;
   localparam logic [1:0] PAN_PAUSE_ASYM = 2'h2;
   localparam logic [1:0] PAN_PAUSE_BOTH = 2'h3;

   // Ability word layout, shared by advertisement and partner registers
   typedef struct packed {
      logic       next_page;
      logic       ack;
      logic       remote_fault;
      logic       spare12;
      logic [1:0] pause;
      logic       t4;
      logic       tx_fd;
      logic       tx;
      logic       t10_fd;
      logic       t10;
      logic [4:0] selector;
   } pan_ability_t;

   // Strap capture sequencer
   typedef enum logic [3:0] {
      PAN_ST_WAIT1 = 4'b0001,
      PAN_ST_WAIT2 = 4'b0010,
      PAN_ST_TAKE  = 4'b0100,
      PAN_ST_RUN   = 4'b1000
   } pan_state_t;

endpackage : pan_pkg

/* File: design/pan_pause_resolve.sv */
// Pause resolution at the end of auto-negotiation
`timescale 1ns/1ps
`default_nettype none
module pan_pause_resolve
   import pan_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       resolve,
   input  wire logic       clear,
   input  wire logic [1:0] local_pause,
   input  wire logic [1:0] partner_pause,
   output var  logic [1:0] pause_mode
);

   logic [1:0] common;
   logic [1:0] pick;

   assign common = local_pause & partner_pause;
   // Symmetric wins over asymmetric so only one setting is ever taken
   assign pick   = common[0] ? PAN_PAUSE_SYM :
                   common[1] ? PAN_PAUSE_ASYM : PAN_PAUSE_NONE;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pause_mode <= PAN_PAUSE_NONE;
      end else if (resolve) begin
         // Completion in the same cycle as a restart keeps the new result
         pause_mode <= pick;
      end else if (clear) begin
         pause_mode <= PAN_PAUSE_NONE;
      end
   end

endmodule : pan_pause_resolve
`default_nettype wire

/* File: design/pan_regs.sv */
// APB register bank for PHY identifier, advertisement and partner ability
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Identifier word bits 15..10 give fixed organisation identifier bits 19 to 24
// - Identifier word bits 9..4 give a fixed six-bit model number
// - Identifier word bits 3..0 give a fixed four-bit revision number
// - Advertisement bit 13 remote fault is writable, resets to zero
// - Advertisement pause field bits 11..10 is writable, resets to zero
// - With both pause kinds advertised, completion selects at most one pause setting
// - Advertisement bits 8, 6, 5 reset from the speed-select strap
// - Advertisement bit 7, 100 Mbit ability, is writable and resets to one
// - Advertisement selector field is writable and resets to the IEEE 802.3 code
// - Partner next-page bit is read-only zero; next pages are not supported
// - Partner acknowledge bit always reads zero
// - Partner pause field is read-only, resets to zero, same codes
// - Partner 100BASE-T4 bit is read-only, resets to zero
// - Partner fault and speed bits read-only, reset zero; selector resets to 00001
// - Self-clearing restart control restarts negotiation using current advertisement
module pan_regs
   import pan_pkg::*;
#(
   parameter logic [5:0] OUI_BITS = 6'h15,   // Arbitrary identity value
   parameter logic [5:0] MODEL    = 6'h2A,   // Arbitrary identity value
   parameter logic [3:0] REVISION = 4'h1     // Arbitrary identity value
)
(
   input  wire logic                  clock,
   input  wire logic                  resetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [PAN_ADDR_W-1:0] paddr,
   input  wire logic [PAN_DATA_W-1:0] pwdata,
   input  wire logic [3:0]            pstrb,
   output var  logic [PAN_DATA_W-1:0] prdata,
   output var  logic                  pready,
   output var  logic                  pslverr,
   input  wire logic                  speed_sel,
   input  wire logic                  lcw_valid,
   input  wire pan_ability_t          lcw_word,
   input  wire logic                  an_complete,
   output var  pan_ability_t          adv_word,
   output var  logic                  an_restart,
   output var  logic [1:0]            pause_mode
);

   // Strap synchroniser and capture sequencer
   logic       strap_meta;
   logic       strap_sync;
   pan_state_t state;
   pan_state_t next_state;

   // Register storage
   pan_ability_t adv;
   pan_ability_t lp;
   logic         done_seen;
   logic         done_prev;

   // Bus decode
   logic [5:0]  word_idx;
   logic        aligned;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        hit_id;
   logic        hit_adv;
   logic        hit_lp;
   logic        mapped;
   logic        setup;
   logic        access;
   logic        wr_en;
   logic [15:0] lane_mask;
   logic [15:0] wdata16;
   logic [15:0] id_word;
   logic [15:0] stat_word;
   logic [15:0] lp_view;
   logic [15:0] rd_word;
   logic [15:0] adv_bits;
   logic [15:0] adv_merge;
   logic        wr_adv;
   logic        wr_restart;
   logic        done_rise;
   logic        take_strap;

   // ------------------------------------------------------------------
   // Strap input: two flip-flops before anything reads it
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end else begin
         strap_meta <= speed_sel;
         strap_sync <= strap_meta;
      end
   end

   // Wait for the synchroniser to fill, take the strap once, then run
   always_comb begin
      next_state = state;
      unique case (state)
         PAN_ST_WAIT1: begin
            next_state = PAN_ST_WAIT2;
         end
         PAN_ST_WAIT2: begin
            next_state = PAN_ST_TAKE;
         end
         PAN_ST_TAKE: begin
            next_state = PAN_ST_RUN;
         end
         PAN_ST_RUN: begin
            next_state = PAN_ST_RUN;
         end
         default: begin
            next_state = PAN_ST_WAIT1;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= PAN_ST_WAIT1;
      end else begin
         state <= next_state;
      end
   end

   assign take_strap = (state == PAN_ST_TAKE);

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   assign word_idx  = paddr[7:2];
   assign aligned   = (paddr[1:0] == 2'h0);
   assign hit_ctrl  = aligned && (word_idx == PAN_IDX_CTRL);
   assign hit_stat  = aligned && (word_idx == PAN_IDX_STAT);
   assign hit_id    = aligned && (word_idx == PAN_IDX_ID);
   assign hit_adv   = aligned && (word_idx == PAN_IDX_ADV);
   assign hit_lp    = aligned && (word_idx == PAN_IDX_LP);
   assign mapped    = hit_ctrl | hit_stat | hit_id | hit_adv | hit_lp;
   assign setup     = psel && !penable;
   assign access    = psel && penable && pready;
   assign wr_en     = access && pwrite && mapped;

   // Only the two low byte lanes carry register bits
   assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wdata16   = pwdata[15:0];

   // Read-only words ignore writes; only control and advertisement change
   assign wr_adv     = wr_en && hit_adv;
   assign wr_restart = wr_en && hit_ctrl && pstrb[1]
                       && wdata16[PAN_CTRL_RESTART_BIT];

   // ------------------------------------------------------------------
   // Read views
   // ------------------------------------------------------------------
   assign id_word = {OUI_BITS, MODEL, REVISION};

   // Next page, acknowledge and bit 12 are masked to zero
   assign lp_view = lp & PAN_LP_RD_MASK;

   assign stat_word = {{(PAN_REG_W-PAN_STAT_DONE_BIT-1){1'b0}},
                       done_seen,
                       {(PAN_STAT_DONE_BIT-2){1'b0}},
                       pause_mode};

   assign rd_word = hit_id   ? id_word   :
                    hit_adv  ? adv       :
                    hit_lp   ? lp_view   :
                    hit_stat ? stat_word :
                    16'h0000;

   // ------------------------------------------------------------------
   // APB answer: one setup cycle, then access with pready already high
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prdata <= '0;
      end else if (setup && !pwrite) begin
         prdata <= {{(PAN_DATA_W-PAN_REG_W){1'b0}}, rd_word};
      end else if (access) begin
         prdata <= '0;
      end
   end

   // ------------------------------------------------------------------
   // Advertisement register
   // ------------------------------------------------------------------
   assign adv_bits  = (adv & ~(PAN_ADV_WR_MASK & lane_mask))
                      | (wdata16 & PAN_ADV_WR_MASK & lane_mask);
   assign adv_merge = adv_bits;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         adv.next_page    <= 1'b0;
         adv.ack          <= 1'b0;
         adv.remote_fault <= 1'b0;
         adv.spare12      <= 1'b0;
         adv.pause        <= PAN_PAUSE_RST;
         adv.t4           <= 1'b0;
         adv.tx_fd        <= 1'b0;
         adv.tx           <= PAN_TX_RST;
         adv.t10_fd       <= 1'b0;
         adv.t10          <= 1'b0;
         adv.selector     <= PAN_SEL_8023;
      end else if (take_strap) begin
         // Strap picks the default speed abilities once after reset
         adv.tx_fd  <= strap_sync;
         adv.t10_fd <= strap_sync;
         adv.t10    <= strap_sync;
      end else if (wr_adv) begin
         adv <= adv_merge;
      end
   end

   assign adv_word = adv;

   // ------------------------------------------------------------------
   // Restart pulse, self-clearing
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         an_restart <= 1'b0;
      end else begin
         an_restart <= wr_restart;
      end
   end

   // ------------------------------------------------------------------
   // Partner ability register
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         lp.next_page    <= 1'b0;
         lp.ack          <= 1'b0;
         lp.remote_fault <= 1'b0;
         lp.spare12      <= 1'b0;
         lp.pause        <= PAN_PAUSE_NONE;
         lp.t4           <= 1'b0;
         lp.tx_fd        <= 1'b0;
         lp.tx           <= 1'b0;
         lp.t10_fd       <= 1'b0;
         lp.t10          <= 1'b0;
         lp.selector     <= PAN_SEL_8023;
      end else if (lcw_valid) begin
         lp           <= lcw_word;
         lp.next_page <= 1'b0;
         lp.ack       <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Completion tracking and pause resolution
   // ------------------------------------------------------------------
   assign done_rise = an_complete && !done_prev;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         done_prev <= 1'b0;
         done_seen <= 1'b0;
      end else begin
         done_prev <= an_complete;
         if (done_rise) begin
            done_seen <= 1'b1;
         end else if (an_restart) begin
            done_seen <= 1'b0;
         end
      end
   end

   pan_pause_resolve u_pause (
      .clock         (clock),
      .resetn        (resetn),
      .resolve       (done_rise),
      .clear         (an_restart),
      .local_pause   (adv.pause),
      .partner_pause (lp.pause),
      .pause_mode    (pause_mode)
   );

endmodule : pan_regs
`default_nettype wire

/* File: tb/pan_regs_asserts.sv */
// Concurrent checks on the PHY ability register bank ports
`timescale 1ns/1ps
`default_nettype none
module pan_regs_asserts
   import pan_pkg::*;
#(
   parameter logic [5:0] OUI_BITS = 6'h15,
   parameter logic [5:0] MODEL    = 6'h2A,
   parameter logic [3:0] REVISION = 4'h1
)
(
   input wire logic                  clock,
   input wire logic                  resetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [PAN_ADDR_W-1:0] paddr,
   input wire logic [PAN_DATA_W-1:0] pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic [PAN_DATA_W-1:0] prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  speed_sel,
   input wire logic                  lcw_valid,
   input wire pan_ability_t          lcw_word,
   input wire logic                  an_complete,
   input wire pan_ability_t          adv_word,
   input wire logic                  an_restart,
   input wire logic [1:0]            pause_mode
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   wire       acc    = psel && penable && pready;
   wire [5:0] idx    = paddr[7:2];
   wire       rd_id  = acc && !pwrite && paddr == 8'h0C;
   wire       rd_adv = acc && !pwrite && paddr == 8'h10;
   wire       rd_lp  = acc && !pwrite && paddr == 8'h14;
   wire       wr_adv = acc && pwrite && paddr == 8'h10 && pstrb == 4'hF;
   wire       wr_rst = acc && pwrite && paddr == 8'h00 && pstrb[1] && pwdata[9];
   wire       bad    = acc && (idx == 6'd2 || idx > 6'd5 || paddr[1:0] != 2'b00);
   wire [15:0] wd16  = pwdata[15:0];

   oui_field_a: assert property (rd_id |-> prdata[15:10] == OUI_BITS) else $error("oui bits wrong");
   model_field_a: assert property (rd_id |-> prdata[9:4] == MODEL) else $error("model wrong");
   rev_field_a: assert property (rd_id |-> prdata[3:0] == REVISION) else $error("revision wrong");
   adv_write_a: assert property (wr_adv |=> adv_word == ($past(wd16) & PAN_ADV_WR_MASK))
      else $error("advertisement write wrong");
   adv_read_a: assert property (rd_adv |-> prdata == {16'h0000, adv_word})
      else $error("advertisement read wrong");
   lp_fixed_zero_a: assert property (rd_lp |-> prdata[15:14] == 2'b00 && !prdata[12])
      else $error("partner fixed bits not zero");
   restart_pulse_a: assert property (wr_rst |=> an_restart ##1 !an_restart)
      else $error("restart pulse wrong");
   pause_single_a: assert property (pause_mode != PAN_PAUSE_BOTH) else $error("both pause set");
   unmapped_err_a: assert property (bad |-> pslverr) else $error("missing slave error");
   reset_adv_a: assert property ($rose(resetn) |-> adv_word == 16'h0081)
      else $error("advertisement reset wrong");

   cover property (wr_adv);
   cover property (wr_rst ##1 an_restart);
   cover property (pause_mode == PAN_PAUSE_ASYM);
endmodule : pan_regs_asserts
bind pan_regs pan_regs_asserts #(.OUI_BITS(OUI_BITS), .MODEL(MODEL), .REVISION(REVISION)) u_chk (
   .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .speed_sel(speed_sel), .lcw_valid(lcw_valid), .lcw_word(lcw_word), .an_complete(an_complete),
   .adv_word(adv_word), .an_restart(an_restart), .pause_mode(pause_mode));
`default_nettype wire

/* File: tb/pan_partner_model.sv */
// Link partner and negotiation engine stand-in
`timescale 1ns/1ps
`default_nettype none
module pan_partner_model
   import pan_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         resetn,
   input  wire logic         send,
   input  wire pan_ability_t word,
   input  wire logic [3:0]   gap,
   input  wire logic         an_restart,
   output var  logic         lcw_valid,
   output var  pan_ability_t lcw_word,
   output var  logic         an_complete
);
   logic [3:0] wait_cnt;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         lcw_valid <= 1'b0;
         lcw_word <= '0;
         an_complete <= 1'b0;
         wait_cnt <= 4'h0;
      end else begin
         lcw_valid <= send;
         // Word is scrambled outside its valid cycle
         lcw_word <= send ? word : pan_ability_t'(~lcw_word);
         if (send || an_restart) begin
            an_complete <= 1'b0;
         end else if (wait_cnt == 4'h1) begin
            an_complete <= 1'b1;
         end
         if (send) begin
            wait_cnt <= gap + 4'h2;
         end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
         end
      end
   end
endmodule : pan_partner_model
`default_nettype wire

/* File: tb/pan_regs_tb.sv */
// Self-checking bench for the PHY ability register bank
`timescale 1ns/1ps
`default_nettype none
module pan_regs_tb;
   import pan_pkg::*;
   localparam logic [5:0] T_OUI   = 6'h2C; // Arbitrary identity value
   localparam logic [5:0] T_MODEL = 6'h13; // Arbitrary identity value
   localparam logic [3:0] T_REV   = 4'h6;  // Arbitrary identity value
   localparam logic [1:0] ADV_P [5] = '{PAN_PAUSE_BOTH, PAN_PAUSE_BOTH, PAN_PAUSE_SYM, PAN_PAUSE_NONE, PAN_PAUSE_ASYM};
   localparam logic [1:0] LP_P  [5] = '{PAN_PAUSE_BOTH, PAN_PAUSE_ASYM, PAN_PAUSE_ASYM, PAN_PAUSE_SYM, PAN_PAUSE_NONE};
   localparam logic [1:0] RES_P [5] = '{PAN_PAUSE_SYM, PAN_PAUSE_ASYM, PAN_PAUSE_NONE, PAN_PAUSE_NONE, PAN_PAUSE_NONE};
   logic         clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, speed_sel = 1, send = 0;
   logic [7:0]   paddr = '0;
   logic [31:0]  pwdata = '0, prdata, rdat;
   logic [3:0]   pstrb = '0, gap = '0;
   logic         pready, pslverr, lcw_valid, an_complete, an_restart, err;
   logic [1:0]   pause_mode;
   pan_ability_t lcw_word, adv_word, word = '0;
   int           failures = 0, n_tests = 0, n;
   always #2.5 clock = ~clock;

   pan_regs #(.OUI_BITS(T_OUI), .MODEL(T_MODEL), .REVISION(T_REV)) DUT (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .speed_sel(speed_sel), .lcw_valid(lcw_valid), .lcw_word(lcw_word), .an_complete(an_complete),
      .adv_word(adv_word), .an_restart(an_restart), .pause_mode(pause_mode));
   pan_partner_model u_partner (.clock(clock), .resetn(resetn), .send(send), .word(word), .gap(gap),
      .an_restart(an_restart), .lcw_valid(lcw_valid), .lcw_word(lcw_word), .an_complete(an_complete));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      k = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("pready", {31'h0, pready}, 32'h1);
   endtask : apb

   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      check(name, rdat, exp);
      check("read error", {31'h0, err}, 32'h0);
   endtask : rd

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (5000) @(posedge clock);
      failures++;
      final_report;
   end

   initial begin
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      check("adv port", {16'h0, adv_word}, 32'h0000_01E1);
      rd("adv", 8'h10, 32'h0000_01E1);
      rd("id", 8'h0C, {16'h0, T_OUI, T_MODEL, T_REV});
      rd("partner", 8'h14, 32'h0000_0001);
      rd("ctrl", 8'h00, 32'h0000_0000);
      $display("test reset values done");
      apb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
      rd("adv ones", 8'h10, 32'h0000_3DFF);
      apb(1'b1, 8'h10, 32'h0000_0000, 4'h1);
      rd("adv low lane", 8'h10, 32'h0000_3D00);
      apb(1'b1, 8'h10, 32'h0000_2000, 4'h2);
      rd("adv fault", 8'h10, 32'h0000_2000);
      $display("test advertisement writes done");
      apb(1'b1, 8'h0C, 32'h0000_0000, 4'hF);
      rd("id kept", 8'h0C, {16'h0, T_OUI, T_MODEL, T_REV});
      apb(1'b1, 8'h14, 32'h0000_FFFF, 4'hF);
      rd("partner kept", 8'h14, 32'h0000_0001);
      apb(1'b0, 8'h08, 32'h0, 4'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      apb(1'b1, 8'h11, 32'h0000_FFFF, 4'hF);
      check("unaligned err", {31'h0, err}, 32'h1);
      rd("adv unchanged", 8'h10, 32'h0000_2000);
      $display("test read-only and errors done");
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 8'h10, {20'h0, ADV_P[i], 10'h1E1}, 4'hF);
         rd("adv pause", 8'h10, {20'h0, ADV_P[i], 10'h1E1});
         apb(1'b1, 8'h00, 32'h0000_0200, 4'h2);
         @(posedge clock);
         check("restart", {31'h0, an_restart}, 32'h1);
         @(posedge clock);
         check("pause cleared", {30'h0, pause_mode}, 32'h0);
         rd("status cleared", 8'h04, 32'h0000_0000);
         word <= {2'b11, 1'b1, 1'b1, LP_P[i], 5'h1F, 5'h01};
         gap <= 4'(i * 3);
         send <= 1'b1;
         @(posedge clock);
         send <= 1'b0;
         n = 0;
         while (an_complete !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
         end
         check("complete", {31'h0, an_complete}, 32'h1);
         repeat (2) @(posedge clock);
         check("pause mode", {30'h0, pause_mode}, {30'h0, RES_P[i]});
         rd("status done", 8'h04, {26'h0, 1'b1, 3'h0, RES_P[i]});
         rd("partner word", 8'h14, {18'h0, 1'b1, 1'b0, LP_P[i], 10'h3E1});
      end
      $display("test negotiation cases done");
      speed_sel <= 1'b0;
      resetn <= 1'b0;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      rd("adv strap low", 8'h10, 32'h0000_0081);
      rd("partner reset", 8'h14, 32'h0000_0001);
      $display("test strap reset done");
      final_report;
   end
endmodule : pan_regs_tb
`default_nettype wire
